// File: src/erf_top.v
`include "erf_defs.vh"
module erf_top (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire [3:0] be_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire frame_end_i,
  input wire [15:0] frame_len_i,
  input wire crc_ok_i,
  input wire [47:0] dest_addr_i,
  input wire [47:0] station_addr_i,
  input wire tx_pending_i,
  input wire pause_rcvd_i,
  output reg frame_valid_o,
  output reg frame_accept_o,
  output reg hash_match_o,
  output reg magic_match_o,
  input wire magic_seen_i,
  output reg backpressure_o,
  output reg tx_pending_send_o,
  output reg tx_inhibit_o,
  output reg [6:0] quantum_bytes_o
);
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Only halfword or word enables count; byte-wide writes are dropped whole
  wire be_ok_w = (be_i == 4'hf) || (be_i == 4'h3) || (be_i == 4'hc); // [R17]
  wire wr_ok_w = wr_i && be_ok_w;
  wire rd_ok_w = rd_i && be_ok_w; // [R17]
  wire [1:0] alias_w = addr_i[3:2];
  wire [7:0] base_w = {addr_i[7:4], 4'h0};
  wire [31:0] ht_low_w;
  wire [31:0] ht_high_w;
  wire [31:0] fc_w;
  wire [31:0] test_w;
  wire [31:0] ctl_w;
  wire rx_en_w = ctl_w[`ERF_CTL_RX_EN];
  // Hardware lock guards against software slips during receive
  wire ht_lock_w = rx_en_w && fc_w[`ERF_FC_HASH_EN]; // [R2]
  wire fc_lock_w = rx_en_w; // [R13]

  erf_alias_reg #(.MASK(32'hffff_ffff)) u_ht_low (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(wr_ok_w && base_w == `ERF_HT_LOW_ADDR),
    .lock_i(ht_lock_w),
    .alias_i(alias_w),
    .be_i(be_i),
    .wdata_i(wdata_i),
    .value_o(ht_low_w)
  ); // [R19]

  erf_alias_reg #(.MASK(32'hffff_ffff)) u_ht_high (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(wr_ok_w && base_w == `ERF_HT_HIGH_ADDR),
    .lock_i(ht_lock_w),
    .alias_i(alias_w),
    .be_i(be_i),
    .wdata_i(wdata_i),
    .value_o(ht_high_w)
  ); // [R1]

  erf_alias_reg #(.MASK(`ERF_FC_MASK)) u_fc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(wr_ok_w && base_w == `ERF_FILT_CFG_ADDR),
    .lock_i(fc_lock_w),
    .alias_i(alias_w),
    .be_i(be_i),
    .wdata_i(wdata_i),
    .value_o(fc_w)
  );

  erf_alias_reg #(.MASK(`ERF_TEST_MASK)) u_test (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(wr_ok_w && base_w == `ERF_TEST_ADDR),
    .lock_i(1'b0),
    .alias_i(alias_w),
    .be_i(be_i),
    .wdata_i(wdata_i),
    .value_o(test_w)
  ); // [R18]

  erf_alias_reg #(.MASK(`ERF_CTL_MASK)) u_ctl (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(wr_ok_w && base_w == `ERF_CONTROL_ADDR),
    .lock_i(1'b0),
    .alias_i(alias_w),
    .be_i(be_i),
    .wdata_i(wdata_i),
    .value_o(ctl_w)
  );

  // ----------------------------------------
  // Frame classification
  // ----------------------------------------
  reg [31:0] status_q;
  wire is_runt_w = frame_len_i < `ERF_RUNT_BYTES;
  wire is_bcast_w = &dest_addr_i;
  wire is_mcast_w = dest_addr_i[40] && !is_bcast_w;
  wire is_ucast_w = !dest_addr_i[40];
  wire is_me_w = dest_addr_i == station_addr_i;
  // Hash index from a six-bit XOR fold of all 48 address bits
  wire [5:0] hash_idx_w = dest_addr_i[5:0] ^ dest_addr_i[11:6] ^ dest_addr_i[17:12]
    ^ dest_addr_i[23:18] ^ dest_addr_i[29:24] ^ dest_addr_i[35:30]
    ^ dest_addr_i[41:36] ^ dest_addr_i[47:42];
  wire [63:0] table_w = {ht_high_w, ht_low_w};
  wire hash_hit_w = table_w[hash_idx_w]; // [R11]
  wire magic_hit_w = magic_seen_i; // [R12]
  reg mand_ok;
  reg addr_ok;

  always @*
  begin
    mand_ok = 1'b1;
    addr_ok = 1'b0;
    if (fc_w[`ERF_FC_CRC_ERR] && crc_ok_i)
      mand_ok = 1'b0; // [R3]
    if (fc_w[`ERF_FC_CRC_OK] && !crc_ok_i)
      mand_ok = 1'b0; // [R4]
    if (fc_w[`ERF_FC_RUNT_COL] && !(is_runt_w && (crc_ok_i || !fc_w[`ERF_FC_CRC_OK])))
      mand_ok = 1'b0; // [R5]
    if (fc_w[`ERF_FC_RUNT_REJ] && is_runt_w)
      mand_ok = 1'b0; // [R6]
    if (fc_w[`ERF_FC_UCAST] && is_ucast_w && is_me_w)
      addr_ok = 1'b1; // [R7]
    if (fc_w[`ERF_FC_NOTME] && is_ucast_w && !is_me_w)
      addr_ok = 1'b1; // [R8]
    if (fc_w[`ERF_FC_MCAST] && is_mcast_w)
      addr_ok = 1'b1; // [R9]
    if (fc_w[`ERF_FC_BCAST] && is_bcast_w)
      addr_ok = 1'b1; // [R10]
    if (fc_w[`ERF_FC_HASH_EN] && hash_hit_w)
      addr_ok = 1'b1;
    if (fc_w[`ERF_FC_MAGIC_EN] && magic_hit_w)
      addr_ok = 1'b1;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      frame_valid_o <= 1'b0;
      frame_accept_o <= 1'b0;
      hash_match_o <= 1'b0;
      magic_match_o <= 1'b0;
      status_q <= `ERF_RST_WORD;
    end
    else
    begin
      frame_valid_o <= frame_end_i && rx_en_w;
      frame_accept_o <= frame_end_i && rx_en_w && mand_ok && addr_ok; // [R21]
      if (frame_end_i)
      begin
        hash_match_o <= hash_hit_w; // [R11]
        magic_match_o <= magic_hit_w; // [R12]
      end
      // Software reads this as last frame result
      if (frame_end_i && rx_en_w)
        status_q <= {28'h0, magic_hit_w, hash_hit_w, addr_ok, mand_ok && addr_ok};
    end
  end

  // ----------------------------------------
  // MAC test controls
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      backpressure_o <= 1'b0;
      tx_pending_send_o <= 1'b0;
      tx_inhibit_o <= 1'b0;
      quantum_bytes_o <= `ERF_QUANTUM_BYTES;
    end
    else
    begin
      backpressure_o <= test_w[`ERF_TST_BP]; // [R14]
      tx_pending_send_o <= tx_pending_i && !(pause_rcvd_i || test_w[`ERF_TST_PAUSE]); // [R14]
      tx_inhibit_o <= pause_rcvd_i || test_w[`ERF_TST_PAUSE]; // [R15]
      quantum_bytes_o <= test_w[`ERF_TST_SHORT] ? `ERF_QUANTUM_SHORT : `ERF_QUANTUM_BYTES; // [R16]
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
      rdata_o <= `ERF_RST_WORD;
    else if (rd_ok_w && alias_w == `ERF_ALIAS_WR)
    begin
      case (base_w)
        `ERF_HT_LOW_ADDR: rdata_o <= ht_low_w;
        `ERF_HT_HIGH_ADDR: rdata_o <= ht_high_w;
        `ERF_FILT_CFG_ADDR: rdata_o <= fc_w;
        `ERF_TEST_ADDR: rdata_o <= test_w; // [R18]
        `ERF_CONTROL_ADDR: rdata_o <= ctl_w;
        `ERF_STATUS_ADDR: rdata_o <= status_q;
        default: rdata_o <= `ERF_RST_WORD;
      endcase
    end
    else
      rdata_o <= `ERF_RST_WORD;
  end
endmodule

// File: common/erf_defs.vh
`ifndef ERF_DEFS_VH
`define ERF_DEFS_VH
// Behaviour
// [R1] Upper 32 bits of the 64-bit receive hash table, receive use only.
// [R2] Software changes hash table only with receive or hash filter disabled.
// [R3] CRC error collection set: accept only frames with bad CRC.
// [R4] CRC valid filter set: accept only frames with good CRC.
// [R5] Runt collection set: accept only runts, good-CRC runts when CRC filter set.
// [R6] Runt reject set: refuse every frame shorter than 64 bytes.
// [R7] Unicast accept: take unicast frames addressed to our station.
// [R8] Foreign unicast accept: take unicast frames addressed elsewhere.
// [R9] Multicast accept: take every multicast destination frame.
// [R10] Broadcast accept: take every broadcast destination frame.
// [R11] Hash match is computed whatever the hash filter enable says.
// [R12] Magic frame match is computed whatever its enable says.
// [R13] Software changes filter configuration only with receive disabled.
// [R14] Test backpressure sends preamble for carrier sense, pending frame still sent.
// [R15] Test pause holds off transmission as if a nonzero pause arrived.
// [R16] Shortcut quanta makes one pause quantum 1 byte-time, not 64.
// [R17] 16 and 32-bit accesses work, aliases included; 8-bit ignored.
// [R18] Test register upper bits read zero; only three low bits writable.
// [R19] Lower 32 bits of the hash table in a companion register.
// [R20] Clear, set, invert aliases at plus 0x4, 0x8, 0xc.
// [R21] Accept when mandatory criteria hold and one address filter matches.

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ERF_HT_LOW_ADDR 8'h00
`define ERF_HT_HIGH_ADDR 8'h10
`define ERF_FILT_CFG_ADDR 8'h20
`define ERF_TEST_ADDR 8'h30
`define ERF_CONTROL_ADDR 8'h40
`define ERF_STATUS_ADDR 8'h50

// ----------------------------------------
// Alias offsets
// ----------------------------------------
`define ERF_ALIAS_WR 2'h0
`define ERF_ALIAS_CLR 2'h1
`define ERF_ALIAS_SET 2'h2
`define ERF_ALIAS_INV 2'h3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ERF_CTL_RX_EN 8
`define ERF_FC_HASH_EN 15
`define ERF_FC_MAGIC_EN 14
`define ERF_FC_CRC_ERR 7
`define ERF_FC_CRC_OK 6
`define ERF_FC_RUNT_COL 5
`define ERF_FC_RUNT_REJ 4
`define ERF_FC_UCAST 3
`define ERF_FC_NOTME 2
`define ERF_FC_MCAST 1
`define ERF_FC_BCAST 0
`define ERF_TST_BP 2
`define ERF_TST_PAUSE 1
`define ERF_TST_SHORT 0

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define ERF_RST_WORD 32'h0000_0000
`define ERF_TEST_MASK 32'h0000_0007
`define ERF_FC_MASK 32'h0000_c0ff
`define ERF_CTL_MASK 32'h0000_0100

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define ERF_RUNT_BYTES 16'd64
`define ERF_QUANTUM_BYTES 7'd64
`define ERF_QUANTUM_SHORT 7'd1
`endif

// File: src/erf_alias_reg.v
`include "erf_defs.vh"
module erf_alias_reg #(
  parameter [31:0] MASK = 32'hffff_ffff
) (
  input wire clk_i,
  input wire rst_i,
  input wire sel_i,
  input wire lock_i,
  input wire [1:0] alias_i,
  input wire [3:0] be_i,
  input wire [31:0] wdata_i,
  output reg [31:0] value_o
);
  // ----------------------------------------
  // Lane mask from byte enables
  // ----------------------------------------
  wire [31:0] lane_w = {{8{be_i[3]}}, {8{be_i[2]}}, {8{be_i[1]}}, {8{be_i[0]}}} & MASK;
  reg [31:0] next_d;

  always @*
  begin
    next_d = value_o;
    case (alias_i) // [R20]
      `ERF_ALIAS_WR: next_d = (value_o & ~lane_w) | (wdata_i & lane_w);
      `ERF_ALIAS_CLR: next_d = value_o & ~(wdata_i & lane_w);
      `ERF_ALIAS_SET: next_d = value_o | (wdata_i & lane_w);
      default: next_d = value_o ^ (wdata_i & lane_w);
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      value_o <= `ERF_RST_WORD;
    else if (sel_i && !lock_i)
      value_o <= next_d & MASK; // [R18]
  end
endmodule

// File: test/erf_checker.sv
`include "erf_defs.vh"
module erf_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [3:0] be_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic frame_end_i,
  input wire logic magic_seen_i,
  input wire logic frame_valid_o,
  input wire logic frame_accept_o,
  input wire logic hash_match_o,
  input wire logic magic_match_o,
  input wire logic [6:0] quantum_bytes_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----
  // Register reads and quantum size
  // ----
  sequence s_rd_test;
    rd_i && addr_i == `ERF_TEST_ADDR && be_i == 4'hf;
  endsequence
  property p_test_high_zero;
    s_rd_test |=> rdata_o[31:3] == 29'h0;
  endproperty
  a_test_high_zero: assert property (p_test_high_zero) else $error("test reg high bits set");
  property p_byte_read;
    rd_i && be_i == 4'h1 |=> rdata_o == 32'h0;
  endproperty
  a_byte_read: assert property (p_byte_read) else $error("byte read not ignored");
  property p_alias_read;
    rd_i && addr_i[3:2] != 2'h0 |=> rdata_o == 32'h0;
  endproperty
  a_alias_read: assert property (p_alias_read) else $error("alias read not zero");
  property p_quanta;
    quantum_bytes_o == 7'd64 || quantum_bytes_o == 7'd1;
  endproperty
  a_quanta: assert property (p_quanta) else $error("bad quantum size");
  // ----
  // Frame results
  // ----
  property p_hash_hold;
    !frame_end_i |=> $stable(hash_match_o);
  endproperty
  a_hash_hold: assert property (p_hash_hold) else $error("hash match moved without frame");
  property p_magic_follow;
    frame_end_i |=> magic_match_o == $past(magic_seen_i);
  endproperty
  a_magic_follow: assert property (p_magic_follow) else $error("magic match wrong");
  property p_accept_valid;
    frame_accept_o |-> frame_valid_o;
  endproperty
  a_accept_valid: assert property (p_accept_valid) else $error("accept without frame");
  property p_valid_cause;
    frame_valid_o |-> $past(frame_end_i);
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("frame pulse without end");
endmodule
bind erf_top erf_checker erf_checker_i (.clk_i, .rst_i, .addr_i, .be_i, .rd_i, .rdata_o, .frame_end_i,
  .magic_seen_i, .frame_valid_o, .frame_accept_o, .hash_match_o, .magic_match_o, .quantum_bytes_o);

// File: test/erf_phy_model.sv
module erf_phy_model (
  input wire logic clk_i,
  output logic frame_end_o,
  output logic [15:0] frame_len_o,
  output logic crc_ok_o,
  output logic [47:0] dest_addr_o,
  output logic magic_seen_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {frame_end_o, frame_len_o, crc_ok_o, dest_addr_o, magic_seen_o} = '0;
  // Fields inverted after the pulse so stale values never look valid
  task automatic send(input logic [15:0] len, input logic crc, input logic [47:0] da, input logic mg);
    @(posedge clk_i);
    frame_end_o <= 1'b1;
    {frame_len_o, crc_ok_o, dest_addr_o, magic_seen_o} <= {len, crc, da, mg};
    @(posedge clk_i);
    frame_end_o <= 1'b0;
    {frame_len_o, crc_ok_o, dest_addr_o, magic_seen_o} <= ~{len, crc, da, mg};
    #1;
  endtask
endmodule

// File: test/test_ethernet_rx_filter_and_mac_test.sv
`include "erf_defs.vh"
module test_ethernet_rx_filter_and_mac_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, wr_i, rd_i, frame_end_i, crc_ok_i, magic_seen_i, tx_pending_i, pause_rcvd_i;
  logic frame_valid_o, frame_accept_o, hash_match_o, magic_match_o, backpressure_o, tx_pending_send_o;
  logic tx_inhibit_o;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [3:0] be_i;
  logic [15:0] frame_len_i;
  logic [47:0] dest_addr_i, station_addr_i;
  logic [6:0] quantum_bytes_o;
  int n_errors = 0;
  int n_checks = 0;
  localparam logic [7:0] HTL = `ERF_HT_LOW_ADDR;
  localparam logic [7:0] HTH = `ERF_HT_HIGH_ADDR;
  localparam logic [7:0] FC = `ERF_FILT_CFG_ADDR;
  localparam logic [7:0] TST = `ERF_TEST_ADDR;
  localparam logic [7:0] CTL = `ERF_CONTROL_ADDR;
  // Case word: cfg, dest pick, length pick, crc, expected accept
  logic [15:0] tc [14] = '{16'h0803, 16'h0842, 16'h0443, 16'h0283, 16'h01c3, 16'h41c0, 16'h81c1,
    16'h81c2, 16'h11d2, 16'h11e3, 16'h21d3, 16'h21e2, 16'h00c2, 16'h61d0};
  logic [15:0] lens [3] = '{16'd100, 16'd63, 16'd64};
  logic [47:0] das [4] = '{48'h0200_0000_0001, 48'h0200_0000_0099, 48'h0100_5e00_0001, '1};
  erf_top erf_top_i (.clk_i, .rst_i, .addr_i, .wdata_i, .be_i, .wr_i, .rd_i, .rdata_o, .frame_end_i,
    .frame_len_i, .crc_ok_i, .dest_addr_i, .station_addr_i, .tx_pending_i, .pause_rcvd_i, .frame_valid_o,
    .frame_accept_o, .hash_match_o, .magic_match_o, .magic_seen_i, .backpressure_o, .tx_pending_send_o,
    .tx_inhibit_o, .quantum_bytes_o);
  erf_phy_model erf_phy_model_i (.clk_i, .frame_end_o(frame_end_i), .frame_len_o(frame_len_i),
    .crc_ok_o(crc_ok_i), .dest_addr_o(dest_addr_i), .magic_seen_o(magic_seen_i));
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b = 4'hf);
    @(posedge clk_i);
    {addr_i, wdata_i, be_i, wr_i} <= {a, d, b, 1'b1};
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [3:0] b = 4'hf);
    @(posedge clk_i);
    {addr_i, be_i, rd_i} <= {a, b, 1'b1};
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  // Config only taken with receive off, so drop it around each change
  task automatic fcase(input logic [7:0] cfg, input logic [15:0] len, input logic crc, input logic [47:0] da);
    wr(CTL, 32'h0);
    wr(FC, {24'h0, cfg});
    wr(CTL, 32'h100);
    erf_phy_model_i.send(len, crc, da, 1'b0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----
  // Sequence
  // ----
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial
  begin
    #50us;
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    {rst_i, wr_i, rd_i, tx_pending_i, pause_rcvd_i} = 5'h10;
    {addr_i, wdata_i, be_i} = '0;
    station_addr_i = das[0];
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk(quantum_bytes_o, 32'd64);
    for (int a = 0; a < 'h70; a += 'h10) rd(a[7:0], 32'h0);
    tx_pending_i <= 1'b1;
    wr(TST, '1);
    rd(TST, 32'h7);
    chk({backpressure_o, tx_inhibit_o, quantum_bytes_o}, {2'h3, 7'd1});
    wr(TST + 8'h4, 32'h6);
    rd(TST, 32'h1);
    wr(TST + 8'h8, 32'h4);
    rd(TST, 32'h5);
    chk({backpressure_o, tx_pending_send_o, tx_inhibit_o}, 32'h6);
    wr(TST + 8'hc, 32'h7);
    rd(TST, 32'h2);
    chk({backpressure_o, tx_inhibit_o, quantum_bytes_o}, {2'h1, 7'd64});
    rd(TST + 8'h8, 32'h0);
    wr(TST, 32'h0, 4'h1);
    rd(TST, 32'h0, 4'h1);
    rd(TST, 32'h2);
    wr(HTH, '1, 4'hc);
    rd(HTH, 32'hffff_0000);
    wr(HTL, '1);
    rd(HTL, '1);
    wr(FC, 32'h8000);
    wr(CTL, 32'h100);
    wr(HTH, 32'h0);
    rd(HTH, 32'hffff_0000);
    wr(FC, 32'h0);
    rd(FC, 32'h8000);
    fcase(8'h0, 16'd100, 1'b1, das[3]);
    wr(HTH, '1);
    rd(HTH, '1);
    erf_phy_model_i.send(16'd100, 1'b1, das[3], 1'b1);
    chk({hash_match_o, magic_match_o}, 32'h3);
    wr(HTL, 32'h0);
    wr(HTH, 32'h0);
    erf_phy_model_i.send(16'd100, 1'b1, das[1], 1'b0);
    chk({hash_match_o, magic_match_o}, 32'h0);
    for (int i = 0; i < 14; i++)
    begin
      fcase(tc[i][15:8], lens[tc[i][5:4]], tc[i][1], das[tc[i][7:6]]);
      chk({frame_valid_o, frame_accept_o}, {1'b1, tc[i][0]});
    end
    rd(8'h50, 32'h2);
    wr(TST, 32'h0);
    rd(TST, 32'h0);
    chk({tx_inhibit_o, tx_pending_send_o}, 32'h1);
    @(posedge clk_i) pause_rcvd_i <= 1'b1;
    rd(TST, 32'h0);
    chk({tx_inhibit_o, tx_pending_send_o}, 32'h2);
    tally_and_finish();
  end
endmodule
